// [common/close_onto_fault_defines.vh]
// Constants of the close-onto-fault window conditioner.
`ifndef CLOSE_ONTO_FAULT_DEFINES_VH
`define CLOSE_ONTO_FAULT_DEFINES_VH
// Clock rate in kHz, and clock cycles per millisecond derived from it.
`define COF_CLK_KHZ          32'h0000_4e20
`define COF_CYCLES_PER_MS    (`COF_CLK_KHZ)
// Fixed pickup delay of the automatic window, in ms.
`define COF_AUTO_PICKUP_MS   32'h0000_00c8
// Drop-off delay limits and reset value, in ms, at the width of the setting.
`define COF_DROP_MIN_MS      14'h0064
`define COF_DROP_MAX_MS      14'h2710
`define COF_DROP_RESET_MS    14'h03e8
// Register byte addresses.
`define COF_ADDR_DROP_DELAY  12'h000
`define COF_ADDR_STATUS      12'h004
// Status register bit positions.
`define COF_ST_AUTO_BIT      0
`define COF_ST_MAN_BIT       1
`define COF_ST_CLOSE_BIT     2
`define COF_ST_DEAD_BIT      3
`endif

// [design/close_onto_fault_conditioner.v]
// Close-onto-fault window conditioner with an AHB-Lite setting and status port.
`timescale 1ns/100ps
`include "close_onto_fault_defines.vh"
//
// Summary of operation
// R1 - Auto window after 200 ms dead line
// R2 - Auto window holds drop-off delay after voltage
// R3 - Manual window holds drop-off delay after command
// R4 - One drop-off delay shared by both windows
// R5 - Auto window depends on dead line only
// R6 - Delay 100 to 10000 ms, reset 1000
// R7 - Detector drives dead line while line dead
// R8 - Manual window rises with command, no delay
module close_onto_fault_conditioner #(
  parameter MS_CYCLES = `COF_CYCLES_PER_MS,
  parameter PICKUP_MS = `COF_AUTO_PICKUP_MS
) (
  // Clock, reset and clock enable.
  input  wire        clock_in,
  input  wire        arst_n_in,
  input  wire        clk_en_in,
  // Binary inputs.
  input  wire        dead_line_in,
  input  wire        manual_breaker_close_cmd_in,
  // Window outputs.
  output wire        auto_close_fault_window_out,
  output wire        manual_close_fault_window_out,
  // AHB-Lite slave.
  input  wire        hsel_in,
  input  wire [11:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output wire [31:0] hrdata_out
);

  // --------------------------------------------------------------------------
  // Millisecond tick
  // --------------------------------------------------------------------------

  reg  [31:0] tick_cnt_ff;
  wire        ms_tick = (tick_cnt_ff == MS_CYCLES - 1);

  // Divides the clock down to one pulse per millisecond.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tick_cnt_ff <= 32'h0000_0000;
    end else if (clk_en_in) begin
      if (ms_tick) begin
        tick_cnt_ff <= 32'h0000_0000;
      end else begin
        tick_cnt_ff <= tick_cnt_ff + 32'h0000_0001;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Bus slave and drop-off setting
  // --------------------------------------------------------------------------

  reg  [13:0] window_dropoff_delay_ff;
  reg         wr_pend_ff;
  reg  [11:0] addr_ff;
  reg  [13:0] delay_view;

  wire        bus_take = hsel_in & htrans_in[1] & hready_in;

  // Clamps a written delay into the legal range.
  function [13:0] clamp_delay;
    input [31:0] val;
    begin
      if (val < `COF_DROP_MIN_MS) begin
        clamp_delay = `COF_DROP_MIN_MS;
      end else if (val > `COF_DROP_MAX_MS) begin
        clamp_delay = `COF_DROP_MAX_MS;
      end else begin
        clamp_delay = val[13:0];
      end
    end
  endfunction

  // Zero wait states while enabled; a frozen block stalls the bus rather than drop a transfer.
  assign hreadyout_out = clk_en_in;
  assign hresp_out     = 1'b0;

  // Captures the address phase and completes writes in the data phase.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_pend_ff             <= 1'b0;
      addr_ff                <= 12'h000;
      // R6 range and reset
      window_dropoff_delay_ff <= `COF_DROP_RESET_MS;
    end else if (clk_en_in) begin
      if (wr_pend_ff && addr_ff == `COF_ADDR_DROP_DELAY) begin
        // R6 clamp the setting
        window_dropoff_delay_ff <= clamp_delay(hwdata_in);
      end
      if (hready_in) begin
        wr_pend_ff <= bus_take & hwrite_in;
        addr_ff    <= haddr_in;
      end
    end
  end

  // A write in its data phase is forwarded, so a read right behind it sees the new value.
  always @* begin
    delay_view = window_dropoff_delay_ff;
    if (wr_pend_ff && addr_ff == `COF_ADDR_DROP_DELAY) begin
      delay_view = clamp_delay(hwdata_in);
    end
  end

  // --------------------------------------------------------------------------
  // Automatic window
  // --------------------------------------------------------------------------

  reg  [13:0] auto_ms_ff;
  reg         auto_win_ff;

  // Times pickup while the line is dead and drop-off once voltage returns.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      auto_ms_ff  <= 14'h0000;
      auto_win_ff <= 1'b0;
    end else if (clk_en_in) begin
      // R5 dead line only
      if (dead_line_in) begin
        if (auto_win_ff) begin
          auto_ms_ff <= 14'h0000;
        end else if (ms_tick) begin
          // R1 fixed pickup
          if (auto_ms_ff == PICKUP_MS - 1) begin
            auto_win_ff <= 1'b1;
            auto_ms_ff  <= 14'h0000;
          end else begin
            auto_ms_ff <= auto_ms_ff + 14'h0001;
          end
        end
      end else if (auto_win_ff) begin
        // R2 drop-off hold
        if (ms_tick) begin
          // R4 shared delay
          if (auto_ms_ff >= window_dropoff_delay_ff - 14'h0001) begin
            auto_win_ff <= 1'b0;
            auto_ms_ff  <= 14'h0000;
          end else begin
            auto_ms_ff <= auto_ms_ff + 14'h0001;
          end
        end
      end else begin
        auto_ms_ff <= 14'h0000;  // Pickup restarts on any gap.
      end
    end
  end

  assign auto_close_fault_window_out = auto_win_ff;

  // --------------------------------------------------------------------------
  // Manual window
  // --------------------------------------------------------------------------

  reg  [13:0] man_ms_ff;
  reg         man_hold_ff;

  // Stretches the manual window after the command falls.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      man_ms_ff   <= 14'h0000;
      man_hold_ff <= 1'b0;
    end else if (clk_en_in) begin
      if (manual_breaker_close_cmd_in) begin
        man_hold_ff <= 1'b1;
        man_ms_ff   <= 14'h0000;
      end else if (man_hold_ff && ms_tick) begin
        // R3 manual drop-off
        if (man_ms_ff >= window_dropoff_delay_ff - 14'h0001) begin
          man_hold_ff <= 1'b0;
          man_ms_ff   <= 14'h0000;
        end else begin
          man_ms_ff <= man_ms_ff + 14'h0001;
        end
      end
    end
  end

  // R8 immediate pickup
  assign manual_close_fault_window_out = manual_breaker_close_cmd_in | man_hold_ff;

  // --------------------------------------------------------------------------
  // Read data
  // --------------------------------------------------------------------------

  reg  [31:0] nxt_hrdata;
  reg  [31:0] hrdata_ff;

  // Picks the word named in the address phase; unmapped addresses and writes give zero.
  always @* begin
    nxt_hrdata = 32'h0000_0000;
    if (bus_take && !hwrite_in) begin
      case (haddr_in)
        `COF_ADDR_DROP_DELAY: nxt_hrdata = {18'h00000, delay_view};
        `COF_ADDR_STATUS: begin
          nxt_hrdata[`COF_ST_AUTO_BIT]  = auto_win_ff;
          nxt_hrdata[`COF_ST_MAN_BIT]   = manual_close_fault_window_out;
          nxt_hrdata[`COF_ST_CLOSE_BIT] = manual_breaker_close_cmd_in;
          nxt_hrdata[`COF_ST_DEAD_BIT]  = dead_line_in;
        end
        default: nxt_hrdata = 32'h0000_0000;
      endcase
    end
  end

  // Holds the read word through the data phase, so read data comes from a flip-flop.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hrdata_ff <= 32'h0000_0000;
    end else if (clk_en_in && hready_in) begin
      hrdata_ff <= nxt_hrdata;
    end
  end

  assign hrdata_out = hrdata_ff;

endmodule // close_onto_fault_conditioner

// [tb/close_onto_fault_properties.sv]
// Checker of the close-onto-fault window timing.
`timescale 1ns/100ps
module cof_window_checker #(
  parameter MS_CYCLES = 4,
  parameter PICKUP_MS = 200
) (
  // Clock, reset and clock enable.
  input wire clock_in,
  input wire arst_n_in,
  input wire clk_en_in,
  // Window inputs and outputs.
  input wire dead_line_in,
  input wire manual_breaker_close_cmd_in,
  input wire auto_close_fault_window_out,
  input wire manual_close_fault_window_out
);
  default clocking @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);
  int hi_ff;
  int lo_ff;
  int idle_ff;
  // Run lengths of the dead line, the live line and the idle command, in enabled cycles.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      hi_ff <= 0;
      lo_ff <= 0;
      idle_ff <= 0;
    end else if (clk_en_in) begin
      hi_ff <= dead_line_in ? hi_ff + 1 : 0;
      lo_ff <= dead_line_in ? 0 : lo_ff + 1;
      idle_ff <= manual_breaker_close_cmd_in ? 0 : idle_ff + 1;
    end
  end
  sequence dead_held;
    dead_line_in [*2] ##0 auto_close_fault_window_out;
  endsequence
  auto_pickup_early_a: assert property (
    $rose(auto_close_fault_window_out) |-> hi_ff >= (PICKUP_MS - 1) * MS_CYCLES)
    else $error("Auto window rose early.");
  auto_pickup_late_a: assert property (
    hi_ff == PICKUP_MS * MS_CYCLES + 3 |-> auto_close_fault_window_out)
    else $error("Auto window rose late.");
  auto_drop_early_a: assert property (
    $fell(auto_close_fault_window_out) |-> lo_ff >= 99 * MS_CYCLES)
    else $error("Auto window dropped early.");
  auto_hold_a: assert property (dead_held |=> auto_close_fault_window_out)
    else $error("Auto window fell on dead line.");
  auto_source_a: assert property (
    !dead_line_in && !auto_close_fault_window_out |=> !auto_close_fault_window_out)
    else $error("Auto window rose without dead line.");
  manual_pickup_a: assert property (
    manual_breaker_close_cmd_in |-> manual_close_fault_window_out)
    else $error("Manual window missing.");
  manual_drop_a: assert property (
    $fell(manual_close_fault_window_out) |-> idle_ff >= 99 * MS_CYCLES)
    else $error("Manual window dropped early.");
endmodule // cof_window_checker
bind close_onto_fault_conditioner cof_window_checker #(
  .MS_CYCLES(MS_CYCLES),
  .PICKUP_MS(PICKUP_MS)
) chk (
  .clock_in(clock_in),
  .arst_n_in(arst_n_in),
  .clk_en_in(clk_en_in),
  .dead_line_in(dead_line_in),
  .manual_breaker_close_cmd_in(manual_breaker_close_cmd_in),
  .auto_close_fault_window_out(auto_close_fault_window_out),
  .manual_close_fault_window_out(manual_close_fault_window_out)
);

// [tb/line_side_model.sv]
// Model of the dead-line detector and the manual close command source.
`timescale 1ns/100ps
module line_side_model (
  // Clock and reset.
  input  wire  clock_in,
  input  wire  arst_n_in,
  // Requests from the bench.
  input  wire  dead_req_in,
  input  wire  close_req_in,
  // Binary status lines.
  output logic dead_line_out,
  output logic close_cmd_out
);
  // dead line and close command levels
  // Lines change only at a clock edge or on reset, as the upstream logic does.
  always @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dead_line_out <= 1'b0;
      close_cmd_out <= 1'b0;
    end else begin
      dead_line_out <= dead_req_in;
      close_cmd_out <= close_req_in;
    end
  end
endmodule // line_side_model

// [tb/test_close_onto_fault_conditioner.sv]
// Testbench of the close-onto-fault window conditioner.
`timescale 1ns/100ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module test_close_onto_fault_conditioner;
  logic clock_in = 0, arst_n_in = 0, hsel_in = 1, clk_en_in = 1, hwrite_in = 0;
  logic dead_req = 0, close_req = 0;
  logic [11:0] haddr_in = 12'h000;
  logic [1:0]  htrans_in = 2'h0;
  logic [2:0]  hsize_in = 3'h2;
  logic [31:0] hwdata_in = 32'h0, rd;
  wire  [31:0] hrdata_out;
  wire dead_line_in, manual_breaker_close_cmd_in, hreadyout_out, hresp_out;
  wire auto_close_fault_window_out, manual_close_fault_window_out;
  wire hready_in = hreadyout_out;
  int error_cnt = 0, n_tests = 0;
  localparam int MS = 4;  // Clock cycles per millisecond in the shortened bench.
  always #25 clock_in = ~clock_in;
  line_side_model far (.clock_in(clock_in), .arst_n_in(arst_n_in), .dead_req_in(dead_req),
    .close_req_in(close_req), .dead_line_out(dead_line_in),
    .close_cmd_out(manual_breaker_close_cmd_in));
  close_onto_fault_conditioner #(.MS_CYCLES(MS)) dut (
    .clock_in(clock_in), .arst_n_in(arst_n_in), .clk_en_in(clk_en_in),
    .dead_line_in(dead_line_in), .manual_breaker_close_cmd_in(manual_breaker_close_cmd_in),
    .auto_close_fault_window_out(auto_close_fault_window_out),
    .manual_close_fault_window_out(manual_close_fault_window_out),
    .hsel_in(hsel_in), .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
    .hsize_in(hsize_in), .hwdata_in(hwdata_in), .hready_in(hready_in),
    .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .hrdata_out(hrdata_out));
  // One single-word bus transfer; read data is taken at the edge that ends the data phase.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_in);
    hwrite_in <= w;
    haddr_in <= a;
    htrans_in <= 2'h2;
    do @(posedge clock_in); while (hready_in !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= d;
    do @(posedge clock_in); while (hready_in !== 1'b1);
    rd = hrdata_out;
  endtask
  // Waits whole milliseconds, then settles at the falling edge.
  task automatic wait_ms(input int n);
    repeat (n * MS) @(posedge clock_in);
    @(negedge clock_in);
  endtask
  task automatic end_sim;
    if (error_cnt == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // Watchdog: the tests need about 6,000 cycles, so 20,000 cycles means a hang.
  initial begin
    repeat (20000) @(posedge clock_in);
    error_cnt++;
    end_sim;
  end
  // Main sequence.
  initial begin
    repeat (8) @(posedge clock_in);
    arst_n_in <= 1'b1;
    xfer(1'b0, 12'h000, 32'h0);
    `CHK("delay reset", 32'h3e8, rd)
    `CHK("resp okay", 1'b0, hresp_out)
    xfer(1'b0, 12'h008, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    @(posedge clock_in);
    close_req <= 1'b1;
    @(posedge clock_in);
    close_req <= 1'b0;
    wait_ms(998);
    `CHK("manual hold", 1'b1, manual_close_fault_window_out)
    wait_ms(3);
    `CHK("manual drop", 1'b0, manual_close_fault_window_out)
    xfer(1'b1, 12'h000, 32'h4e20);
    xfer(1'b0, 12'h000, 32'h0);
    `CHK("delay max", 32'h2710, rd)
    xfer(1'b1, 12'h000, 32'h96);
    xfer(1'b0, 12'h000, 32'h0);
    `CHK("delay mid", 32'h96, rd)
    xfer(1'b1, 12'h000, 32'h32);
    xfer(1'b0, 12'h000, 32'h0);
    `CHK("delay min", 32'h64, rd)
    xfer(1'b1, 12'h004, 32'h3e8);
    xfer(1'b0, 12'h000, 32'h0);
    `CHK("status write ignored", 32'h64, rd)
    @(posedge clock_in);
    dead_req <= 1'b1;
    wait_ms(198);
    `CHK("auto pickup", 1'b0, auto_close_fault_window_out)
    wait_ms(3);
    `CHK("auto on", 1'b1, auto_close_fault_window_out)
    xfer(1'b0, 12'h004, 32'h0);
    `CHK("status", 32'h9, rd)
    @(posedge clock_in);
    dead_req <= 1'b0;
    wait_ms(98);
    `CHK("auto hold", 1'b1, auto_close_fault_window_out)
    wait_ms(3);
    `CHK("auto drop", 1'b0, auto_close_fault_window_out)
    @(posedge clock_in);
    close_req <= 1'b1;
    @(posedge clock_in);
    close_req <= 1'b0;
    @(negedge clock_in);
    `CHK("manual rise", 1'b1, manual_close_fault_window_out)
    `CHK("auto quiet", 1'b0, auto_close_fault_window_out)
    @(posedge clock_in);
    clk_en_in <= 1'b0;
    repeat (160) @(posedge clock_in);
    `CHK("frozen hold", 1'b1, manual_close_fault_window_out)
    clk_en_in <= 1'b1;
    wait_ms(98);
    `CHK("shared hold", 1'b1, manual_close_fault_window_out)
    wait_ms(3);
    `CHK("shared drop", 1'b0, manual_close_fault_window_out)
    end_sim;
  end
endmodule // test_close_onto_fault_conditioner
